// ### quad_wiper_pkg.sv
// Shared constants for the quad wiper setting bank.
// Assumes a single 20 MHz clock domain and a serial bus sampled as plain inputs.
package quad_wiper_pkg;

  localparam int CHANNELS   = 4;
  localparam int SLOTS      = 4;
  localparam int SETTING_W  = 6;
  localparam int TAPS       = 64;
  localparam int CH_W       = 2;
  localparam int SLOT_W     = 2;
  localparam int STORE_AW   = CH_W + SLOT_W;

  // Device type nibble of the slave address byte; value is arbitrary
  localparam logic [3:0] DEV_TYPE = 4'h5;

  // Slave address byte fields
  localparam int ADDR_TYPE_HI  = 7;
  localparam int ADDR_TYPE_LO  = 4;
  localparam int ADDR_STRAP_HI = 3;
  localparam int ADDR_STRAP_LO = 0;

  // Instruction byte fields: opcode, saved slot, channel
  localparam int INSTR_OP_HI   = 7;
  localparam int INSTR_OP_LO   = 4;
  localparam int INSTR_SLOT_HI = 3;
  localparam int INSTR_SLOT_LO = 2;
  localparam int INSTR_CH_HI   = 1;
  localparam int INSTR_CH_LO   = 0;

  // Data byte bit that picks the step direction in step mode
  localparam int STEP_UP_BIT = 0;

  // Instruction opcodes
  localparam logic [3:0] OP_READ_WIPER  = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
  localparam logic [3:0] OP_READ_SAVED  = 4'hB;
  localparam logic [3:0] OP_WRITE_SAVED = 4'hC;
  localparam logic [3:0] OP_RECALL      = 4'hD;
  localparam logic [3:0] OP_STORE       = 4'hE;
  localparam logic [3:0] OP_STEP        = 4'h2;

  // Reset values and the setting maximum
  localparam logic [SETTING_W-1:0] WIPER_RESET = 6'h00;
  localparam logic [SETTING_W-1:0] SAVED_BLANK = 6'h00;
  localparam logic [SETTING_W-1:0] SETTING_MAX = 6'h3F;

  // Byte position within a transfer
  localparam logic [1:0] BYTE_ADDR  = 2'h0;
  localparam logic [1:0] BYTE_INSTR = 2'h1;
  localparam logic [1:0] BYTE_DATA  = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_ACK    = 3'b010,
    ST_TX     = 3'b011,
    ST_TXACK  = 3'b100,
    ST_IGNORE = 3'b101
  } bus_state_t;

endpackage

// ### saved_setting_store.sv
// Saved wiper settings: four slots for each of four channels.
// Assumes eraseReset models a blank part; the normal reset leaves contents intact.
`timescale 1ns/100ps
module saved_setting_store
  import quad_wiper_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          eraseReset,
  input  wire logic                          writeEn,
  input  wire logic [STORE_AW-1:0]           writeAddr,
  input  wire logic [SETTING_W-1:0]          writeData,
  input  wire logic [STORE_AW-1:0]           readAddr,
  output logic      [SETTING_W-1:0]          readData,
  output logic      [CHANNELS*SETTING_W-1:0] firstSlot
);

  logic [SETTING_W-1:0] mem_q [CHANNELS*SLOTS];

  always_ff @(posedge clk or posedge eraseReset)
  begin
    if (eraseReset)
    begin
      for (int i = 0; i < CHANNELS*SLOTS; i++)
      begin
        mem_q[i] <= SAVED_BLANK;
      end
    end
    else if (writeEn)
    begin
      mem_q[writeAddr] <= writeData;
    end
  end

  assign readData = mem_q[readAddr];

  // Slot 0 of each channel feeds the power-up recall
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_first
    assign firstSlot[ch*SETTING_W +: SETTING_W] = mem_q[ch*SLOTS];
  end

endmodule

// ### quad_wiper_setting_bank.sv
// Four-channel wiper setting bank with serial two-wire slave port.
// Assumes scl and sda are synchronous to clk; the pad resolves sda from sdaOe.
`timescale 1ns/100ps

// Functional notes
// - Each of the four channels has its own 6-bit wiper setting that alone picks its tap.
// - Each channel has four 6-bit saved settings that keep their values across a normal reset.
// - Wiper and saved settings are written through transfers issued by the bus master.
// - After reset the first saved setting of every channel is copied into its wiper setting.
// - The write-allow input guards the saved settings against unintended programming.
// - Every one of the 64 codes of a wiper setting selects a distinct tap.
// - Four strap inputs form the bus address, strap bit 0 being the lowest address bit.
// - The device joins a transfer only when the sent address matches its straps, else ignores it.
// - The data line is only ever pulled low or released, never driven high.
// - All data moves in and out on edges of the master's serial clock.
// - With write-allow low saved writes are refused while wiper writes still succeed.
// - Instructions copy between a channel's wiper and its own saved settings, plus a step mode.
module quad_wiper_setting_bank
  import quad_wiper_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          eraseReset,
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  input  wire logic                          strapAddrBit0,
  input  wire logic                          strapAddrBit1,
  input  wire logic                          strapAddrBit2,
  input  wire logic                          strapAddrBit3,
  input  wire logic                          writeAllow,
  output logic      [CHANNELS*SETTING_W-1:0] wiperSetting,
  output logic      [CHANNELS*TAPS-1:0]      tapSelect
);

  bus_state_t           state_q;
  logic                 sclPrev_q;
  logic                 sdaPrev_q;
  logic [7:0]           shift_q;
  logic [2:0]           bitCnt_q;
  logic [1:0]           byteIdx_q;
  logic [7:0]           instr_q;
  logic                 ackPhase_q;
  logic                 sdaOe_q;
  logic                 readOp_q;
  logic [7:0]           txByte_q;
  logic [SETTING_W-1:0] readValue_q;
  logic                 recall_q;
  logic [SETTING_W-1:0] wiper_q [CHANNELS];
  logic [CHANNELS*TAPS-1:0] tapSelect_q;

  logic                 sclRise;
  logic                 sclFall;
  logic                 startCond;
  logic                 stopCond;
  logic                 byteDone;
  logic [7:0]           rxByte;
  logic [7:0]           instrByte;
  logic [3:0]           opcode;
  logic [CH_W-1:0]      chSel;
  logic [SLOT_W-1:0]    slotSel;
  logic [3:0]           strapAddr;
  logic                 addrMatch;
  logic                 ackByte;
  logic                 startRead;
  logic                 wiperWe;
  logic [SETTING_W-1:0] wiperWdata;
  logic                 savedWe;
  logic [SETTING_W-1:0] savedWdata;
  logic [SETTING_W-1:0] savedRdata;
  logic [SETTING_W-1:0] readValue;
  logic [SETTING_W-1:0] curWiper;
  logic [CHANNELS*SETTING_W-1:0] firstSlot;

  // Bus line edges and conditions
  assign sclRise   = sclIn & ~sclPrev_q;
  assign sclFall   = ~sclIn & sclPrev_q;
  assign startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
  assign stopCond  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

  assign rxByte    = {shift_q[6:0], sdaIn};
  assign byteDone  = (state_q == ST_RX) && sclRise && (bitCnt_q == 3'd7);
  assign instrByte = (byteIdx_q == BYTE_INSTR) ? rxByte : instr_q;
  assign opcode    = instrByte[INSTR_OP_HI:INSTR_OP_LO];
  assign chSel     = instrByte[INSTR_CH_HI:INSTR_CH_LO];
  assign slotSel   = instrByte[INSTR_SLOT_HI:INSTR_SLOT_LO];
  assign curWiper  = wiper_q[chSel];

  assign strapAddr = {strapAddrBit3, strapAddrBit2, strapAddrBit1, strapAddrBit0};
  assign addrMatch = (rxByte[ADDR_TYPE_HI:ADDR_TYPE_LO] == DEV_TYPE)
                  && (rxByte[ADDR_STRAP_HI:ADDR_STRAP_LO] == strapAddr);

  assign readValue = (opcode == OP_READ_WIPER) ? curWiper : savedRdata;

  // Per-byte decode: acknowledge and register actions
  always_comb
  begin
    ackByte    = 1'b0;
    startRead  = 1'b0;
    wiperWe    = 1'b0;
    wiperWdata = rxByte[SETTING_W-1:0];
    savedWe    = 1'b0;
    savedWdata = rxByte[SETTING_W-1:0];
    if (byteDone)
    begin
      case (byteIdx_q)
        BYTE_ADDR:
        begin
          ackByte = addrMatch;
        end
        BYTE_INSTR:
        begin
          case (opcode)
            OP_READ_WIPER, OP_READ_SAVED:
            begin
              ackByte   = 1'b1;
              startRead = 1'b1;
            end
            OP_WRITE_WIPER, OP_WRITE_SAVED, OP_STEP:
            begin
              ackByte = 1'b1;
            end
            OP_RECALL:
            begin
              ackByte    = 1'b1;
              wiperWe    = 1'b1;
              wiperWdata = savedRdata;
            end
            OP_STORE:
            begin
              ackByte    = writeAllow;
              savedWe    = writeAllow;
              savedWdata = curWiper;
            end
            default:
            begin
              ackByte = 1'b0;
            end
          endcase
        end
        default:
        begin
          case (opcode)
            OP_WRITE_WIPER:
            begin
              ackByte = 1'b1;
              wiperWe = 1'b1;
            end
            OP_WRITE_SAVED:
            begin
              ackByte = writeAllow;
              savedWe = writeAllow;
            end
            OP_STEP:
            begin
              ackByte = 1'b1;
              wiperWe = 1'b1;
              if (rxByte[STEP_UP_BIT])
              begin
                wiperWdata = (curWiper == SETTING_MAX) ? curWiper : curWiper + 6'h01;
              end
              else
              begin
                wiperWdata = (curWiper == WIPER_RESET) ? curWiper : curWiper - 6'h01;
              end
            end
            default:
            begin
              ackByte = 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // Line history for edge detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
    end
  end

  // Serial transfer engine
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= ST_IDLE;
      shift_q     <= 8'h00;
      bitCnt_q    <= 3'd0;
      byteIdx_q   <= BYTE_ADDR;
      instr_q     <= 8'h00;
      ackPhase_q  <= 1'b0;
      sdaOe_q     <= 1'b0;
      readOp_q    <= 1'b0;
      txByte_q    <= 8'h00;
      readValue_q <= WIPER_RESET;
    end
    else if (startCond)
    begin
      state_q    <= ST_RX;
      bitCnt_q   <= 3'd0;
      byteIdx_q  <= BYTE_ADDR;
      ackPhase_q <= 1'b0;
      sdaOe_q    <= 1'b0;
    end
    else if (stopCond)
    begin
      state_q <= ST_IDLE;
      sdaOe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_RX:
        begin
          if (sclRise)
          begin
            shift_q  <= rxByte;
            bitCnt_q <= bitCnt_q + 3'd1;
            if (bitCnt_q == 3'd7)
            begin
              if (ackByte)
              begin
                state_q    <= ST_ACK;
                ackPhase_q <= 1'b0;
                readOp_q   <= startRead;
                if (byteIdx_q == BYTE_INSTR)
                begin
                  instr_q     <= rxByte;
                  readValue_q <= readValue;
                end
              end
              else
              begin
                state_q <= ST_IGNORE;
              end
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            if (!ackPhase_q)
            begin
              sdaOe_q    <= 1'b1;
              ackPhase_q <= 1'b1;
            end
            else
            begin
              ackPhase_q <= 1'b0;
              bitCnt_q   <= 3'd0;
              if (byteIdx_q != BYTE_DATA)
              begin
                byteIdx_q <= byteIdx_q + 2'd1;
              end
              if (readOp_q)
              begin
                state_q  <= ST_TX;
                txByte_q <= {2'b00, readValue_q};
                sdaOe_q  <= 1'b1;
              end
              else
              begin
                state_q <= ST_RX;
                sdaOe_q <= 1'b0;
              end
            end
          end
        end
        ST_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt_q == 3'd7)
            begin
              state_q <= ST_TXACK;
              sdaOe_q <= 1'b0;
            end
            else
            begin
              bitCnt_q <= bitCnt_q + 3'd1;
              sdaOe_q  <= ~txByte_q[6];
              txByte_q <= {txByte_q[6:0], 1'b0};
            end
          end
        end
        ST_TXACK:
        begin
          if (sclRise)
          begin
            if (sdaIn)
            begin
              state_q <= ST_IGNORE;
            end
            else
            begin
              ackPhase_q <= 1'b1;
            end
          end
          else if (sclFall && ackPhase_q)
          begin
            ackPhase_q <= 1'b0;
            state_q    <= ST_TX;
            bitCnt_q   <= 3'd0;
            txByte_q   <= {2'b00, readValue_q};
            sdaOe_q    <= 1'b1;
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          sdaOe_q <= 1'b0;
        end
        default:
        begin
          state_q <= ST_IDLE;
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // Wiper settings with power-up recall
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      recall_q <= 1'b1;
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        wiper_q[ch] <= WIPER_RESET;
      end
    end
    else if (recall_q)
    begin
      recall_q <= 1'b0;
      for (int ch = 0; ch < CHANNELS; ch++)
      begin
        wiper_q[ch] <= firstSlot[ch*SETTING_W +: SETTING_W];
      end
    end
    else if (wiperWe)
    begin
      wiper_q[chSel] <= wiperWdata;
    end
  end

  // One-hot tap select per channel
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_tap
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        tapSelect_q[ch*TAPS +: TAPS] <= {{(TAPS-1){1'b0}}, 1'b1};
      end
      else
      begin
        tapSelect_q[ch*TAPS +: TAPS] <= {{(TAPS-1){1'b0}}, 1'b1} << wiper_q[ch];
      end
    end
    assign wiperSetting[ch*SETTING_W +: SETTING_W] = wiper_q[ch];
  end

  saved_setting_store u_store (
    .clk        (clk),
    .eraseReset (eraseReset),
    .writeEn    (savedWe),
    .writeAddr  ({chSel, slotSel}),
    .writeData  (savedWdata),
    .readAddr   ({chSel, slotSel}),
    .readData   (savedRdata),
    .firstSlot  (firstSlot)
  );

  assign sdaOut    = 1'b0;
  assign sdaOe     = sdaOe_q;
  assign tapSelect = tapSelect_q;

endmodule

// ### wiper_bank_properties.sv
// Port checker for the wiper setting bank.
// Assumes it is bound into quad_wiper_setting_bank.
`timescale 1ns/100ps
module wiper_bank_properties
  import quad_wiper_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic                          sclIn,
  input wire logic                          sdaIn,
  input wire logic                          sdaOut,
  input wire logic                          sdaOe,
  input wire logic [CHANNELS*SETTING_W-1:0] wiperSetting,
  input wire logic [CHANNELS*TAPS-1:0]      tapSelect
);
  logic [CHANNELS*SETTING_W-1:0] wiperPrev_q;
  logic [CHANNELS*TAPS-1:0]      tapExp;
  logic [CHANNELS-1:0]           chDiff;
  logic                          tapOk;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      wiperPrev_q <= '0;
    else
      wiperPrev_q <= wiperSetting;
  end

  always_comb
  begin
    tapOk = 1'b1;
    for (int c = 0; c < CHANNELS; c++)
    begin
      tapExp[c*TAPS+:TAPS] = TAPS'(1) << wiperPrev_q[c*SETTING_W+:SETTING_W];
      chDiff[c] = wiperPrev_q[c*SETTING_W+:SETTING_W] != wiperSetting[c*SETTING_W+:SETTING_W];
      tapOk = tapOk && ($countones(tapSelect[c*TAPS+:TAPS]) == 1);
    end
  end

  a_drain_only: assert property (@(posedge clk) sdaOut == 1'b0)
    else $error("data line driven high");
  a_tap_decode: assert property (@(posedge clk) disable iff (reset) tapSelect == tapExp)
    else $error("tap select differs from wiper");
  a_tap_onehot: assert property (@(posedge clk) disable iff (reset) tapOk)
    else $error("tap select not one-hot");
  a_channel_alone: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) && !$past(reset, 2) |-> $onehot0(chDiff))
    else $error("several wipers changed at once");
  a_wiper_on_scl: assert property (@(posedge clk) disable iff (reset)
    $changed(wiperSetting) |-> sclIn || $past(reset, 2))
    else $error("wiper changed outside a clock pulse");
  a_oe_low_phase: assert property (@(posedge clk) disable iff (reset) $changed(sdaOe) |-> !$past(sclIn))
    else $error("data driver moved while clock high");
  a_reset_quiet: assert property (@(posedge clk) reset |-> !sdaOe && wiperSetting == '0)
    else $error("outputs active in reset");
  a_stop_release: assert property (@(posedge clk) disable iff (reset)
    sclIn && $past(sclIn) && $rose(sdaIn) |=> !sdaOe [*3])
    else $error("data pulled after stop");
endmodule

bind quad_wiper_setting_bank wiper_bank_properties i_props (
  .clk, .reset, .sclIn, .sdaIn, .sdaOut, .sdaOe, .wiperSetting, .tapSelect
);

// ### i2c_master_model.sv
// Bus master model: drives the serial clock and pulls data low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module i2c_master_model
(
  input  wire logic clk,
  input  wire logic sdaBus,
  output logic      scl,
  output logic      sdaLow
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data falls while clock high
  task automatic start_cond();
    sdaLow = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sdaLow = 1'b1;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic stop_cond();
    sdaLow = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sdaLow = 1'b0;
    wait_clk(4);
  endtask

  // Data set in low phase, sampled mid high phase
  task automatic xfer_bit(input logic b, output logic r);
    sdaLow = !b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(2);
    r = sdaBus;
    wait_clk(2);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic xfer_byte(input logic [7:0] tx, input logic mAck, output logic [7:0] rx, output logic nack);
    for (int i = 7; i >= 0; i--)
      xfer_bit(tx[i], rx[i]);
    xfer_bit(!mAck, nack);
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the wiper setting bank.
// Assumes the master model and port checker are compiled first.
`timescale 1ns/100ps
module tb_top
  import quad_wiper_pkg::*;
;
  logic                          clk;
  logic                          reset;
  logic                          eraseReset;
  logic                          scl;
  logic                          sdaLow;
  logic                          sdaOut;
  logic                          sdaOe;
  logic                          sdaBus;
  logic [3:0]                    straps;
  logic                          writeAllow;
  logic [CHANNELS*SETTING_W-1:0] wiperSetting;
  logic [CHANNELS*TAPS-1:0]      tapSelect;
  logic [7:0]                    addr;
  logic [2:0]                    nacks;
  int                            failures;
  int                            nTests;
  int                            cycles = 0;

  // Open-drain wire with pull-up
  assign sdaBus = !(sdaOe || sdaLow);
  assign addr = {DEV_TYPE, straps};

  quad_wiper_setting_bank i_dut (
    .clk, .reset, .eraseReset, .sclIn(scl), .sdaIn(sdaBus), .sdaOut, .sdaOe,
    .strapAddrBit0(straps[0]), .strapAddrBit1(straps[1]), .strapAddrBit2(straps[2]),
    .strapAddrBit3(straps[3]), .writeAllow, .wiperSetting, .tapSelect
  );

  i2c_master_model i_master (.clk, .sdaBus, .scl, .sdaLow);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    nTests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] instr, input logic [7:0] d, input logic withData);
    logic [7:0] rx;
    i_master.start_cond();
    i_master.xfer_byte(a, 1'b0, rx, nacks[2]);
    i_master.xfer_byte(instr, 1'b0, rx, nacks[1]);
    nacks[0] = 1'b0;
    if (withData)
      i_master.xfer_byte(d, 1'b0, rx, nacks[0]);
    i_master.stop_cond();
    i_master.wait_clk(2);
  endtask

  task automatic rd(input logic [7:0] instr, output logic [7:0] v);
    logic n;
    i_master.start_cond();
    i_master.xfer_byte(addr, 1'b0, v, n);
    i_master.xfer_byte(instr, 1'b0, v, n);
    i_master.xfer_byte(8'hFF, 1'b0, v, n);
    i_master.stop_cond();
    i_master.wait_clk(2);
  endtask

  task automatic t_wiper_rw();
    logic [5:0] vals [4] = '{6'h3F, 6'h00, 6'h15, 6'h2A};
    logic [7:0] v;
    for (int c = 0; c < 4; c++)
    begin
      wr(addr, {OP_WRITE_WIPER, 2'h0, 2'(c)}, {2'h0, vals[c]}, 1'b1);
      check(nacks, 3'h0, "write acks");
    end
    for (int c = 0; c < 4; c++)
    begin
      check(wiperSetting[c*6+:6], vals[c], "wiper");
      check(tapSelect[c*64+:64], 64'h1 << vals[c], "tap");
      rd({OP_READ_WIPER, 2'h0, 2'(c)}, v);
      check(v, {2'h0, vals[c]}, "read wiper");
    end
  endtask

  task automatic t_saved();
    logic [7:0] v;
    for (int s = 0; s < 4; s++)
      wr(addr, {OP_WRITE_SAVED, 2'(s), 2'h1}, 8'(8'h10 + s), 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      rd({OP_READ_SAVED, 2'(s), 2'h1}, v);
      check(v, 8'h10 + s, "saved");
    end
    wr(addr, {OP_RECALL, 2'h3, 2'h1}, 8'h00, 1'b0);
    check(wiperSetting[11:6], 6'h13, "recall");
    wr(addr, {OP_WRITE_WIPER, 2'h0, 2'h2}, 8'h2C, 1'b1);
    wr(addr, {OP_STORE, 2'h1, 2'h2}, 8'h00, 1'b0);
    rd({OP_READ_SAVED, 2'h1, 2'h2}, v);
    check(v, 8'h2C, "store");
    for (int c = 0; c < 4; c++)
      wr(addr, {OP_WRITE_SAVED, 2'h0, 2'(c)}, 8'(8'h20 + c), 1'b1);
    reset = 1'b1;
    i_master.wait_clk(5);
    reset = 1'b0;
    i_master.wait_clk(3);
    for (int c = 0; c < 4; c++)
      check(wiperSetting[c*6+:6], 6'h20 + c, "power-up recall");
  endtask

  task automatic t_lock();
    logic [7:0] v;
    writeAllow = 1'b0;
    wr(addr, {OP_WRITE_SAVED, 2'h0, 2'h0}, 8'h01, 1'b1);
    check(nacks, 3'h1, "locked nack");
    wr(addr, {OP_WRITE_WIPER, 2'h0, 2'h0}, 8'h07, 1'b1);
    check(nacks, 3'h0, "locked wiper ack");
    wr(addr, {OP_STORE, 2'h0, 2'h0}, 8'h00, 1'b0);
    check(nacks[1], 1'b1, "locked store nack");
    writeAllow = 1'b1;
    rd({OP_READ_SAVED, 2'h0, 2'h0}, v);
    check(v, 8'h20, "locked saved");
    check(wiperSetting[5:0], 6'h07, "locked wiper");
  endtask

  task automatic t_address();
    for (int i = 0; i < 5; i++)
    begin
      wr(addr ^ (8'h01 << i), {OP_WRITE_WIPER, 2'h0, 2'h3}, 8'h3F, 1'b1);
      check(nacks[2], 1'b1, "foreign nack");
      check(wiperSetting[23:18], 6'h23, "foreign wiper");
    end
    wr(addr, {4'h0, 2'h0, 2'h3}, 8'h3F, 1'b1);
    check(nacks, 3'h3, "unknown op nack");
    check(wiperSetting[23:18], 6'h23, "unknown op wiper");
  endtask

  task automatic t_step();
    logic [5:0] exp [3] = '{6'h3F, 6'h3F, 6'h3E};
    wr(addr, {OP_WRITE_WIPER, 2'h0, 2'h0}, 8'h3E, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      wr(addr, {OP_STEP, 2'h0, 2'h0}, {7'h00, 1'(i < 2)}, 1'b1);
      check(wiperSetting[5:0], exp[i], "step");
    end
  endtask

  initial
  begin
    reset = 1'b1;
    eraseReset = 1'b1;
    writeAllow = 1'b1;
    straps = 4'hA;
    failures = 0;
    nTests = 0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    eraseReset = 1'b0;
    repeat (3) @(negedge clk);
    check(wiperSetting, 0, "blank recall");
    t_wiper_rw();
    t_saved();
    t_lock();
    t_address();
    t_step();
    conclude();
  end
endmodule
